// ### core/pgpfs_top.sv
// Behaviour
// - modes 1,2,3,7: line 1 is general input (dir 0) or output (dir 1)
// - modes 4-6: line 1 is general input (dir 0) or chip select 3 (dir 1)
// - line 1 level always goes to the interrupt controller as interrupt 7
// - line 0 is general input (dir 0) or output (dir 1) in every mode
// - line 0 feeds converter trigger only when both trigger-source bits are 1
// - line 0 level always goes to the interrupt controller as interrupt 6
// - pin register reads latch when dir is 1, pin level when dir is 0
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "pgpfs_consts.svh"

module pgpfs_top (
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  // operating mode pins
  input  wire logic [`PGPFS_MODE_W-1:0]  mode_pins_in,
  // chip select 3 from the external bus controller, active low
  input  wire logic                      chip_select_three_n_in,
  // register port
  input  wire logic [`PGPFS_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`PGPFS_DATA_W-1:0]  reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [`PGPFS_DATA_W-1:0]  reg_rdata_out,
  // line 1 pin, three signals
  input  wire logic                      port_line_one_in,
  output logic                           port_line_one_out,
  output logic                           port_line_one_oe_out,
  // line 0 pin, three signals
  input  wire logic                      port_line_zero_in,
  output logic                           port_line_zero_out,
  output logic                           port_line_zero_oe_out,
  // to interrupt controller and converter, pin levels (active low events)
  output logic                           ext_interrupt_seven_n_out,
  output logic                           ext_interrupt_six_n_out,
  output logic                           converter_ext_trigger_n_out
);

  // ========================================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  // async assert, release through two flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ========================================================================
  // pin and mode synchronisation
  logic [`PGPFS_SYNC_W-1:0] sync_raw;
  logic [`PGPFS_SYNC_W-1:0] sync_vals;
  logic [`PGPFS_LINES-1:0]  pin_level;
  logic [`PGPFS_MODE_W-1:0] mode_sync;

  // pins and mode straps come from outside the clock domain
  assign sync_raw = {mode_pins_in, port_line_one_in, port_line_zero_in};

  pgpfs_sync u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_reg),
    .async_in (sync_raw),
    .sync_out (sync_vals)
  );

  assign pin_level = sync_vals[`PGPFS_LINES-1:0];
  assign mode_sync = sync_vals[`PGPFS_SYNC_W-1:`PGPFS_LINES];

  // ========================================================================
  // register decode
  logic hit_dir;
  logic hit_latch;
  logic hit_pin;
  logic hit_conv;
  logic hit_status;
  logic wr_dir;
  logic wr_latch;
  logic wr_conv;

  // unmapped offsets read zero and ignore writes
  assign hit_dir    = (reg_addr_in == `PGPFS_OFS_DIRECTION);
  assign hit_latch  = (reg_addr_in == `PGPFS_OFS_OUT_LATCH);
  assign hit_pin    = (reg_addr_in == `PGPFS_OFS_PIN_LEVEL);
  assign hit_conv   = (reg_addr_in == `PGPFS_OFS_CONV_CTRL);
  assign hit_status = (reg_addr_in == `PGPFS_OFS_STATUS);
  assign wr_dir     = reg_wr_in & hit_dir;
  assign wr_latch   = reg_wr_in & hit_latch;
  assign wr_conv    = reg_wr_in & hit_conv;

  // ========================================================================
  // software registers
  logic [`PGPFS_LINES-1:0] dir_reg;
  logic [`PGPFS_LINES-1:0] latch_reg;
  logic [1:0]              trgs_reg;

  // direction bits, one per line
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dir_reg <= `PGPFS_DIR_RESET;
    end else if (wr_dir) begin
      dir_reg <= reg_wdata_in[`PGPFS_LINES-1:0];
    end
  end

  // output latch; pin register itself is read only
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      latch_reg <= `PGPFS_LATCH_RESET;
    end else if (wr_latch) begin
      latch_reg <= reg_wdata_in[`PGPFS_LINES-1:0];
    end
  end

  // trigger-source bits of the converter control register
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      trgs_reg <= `PGPFS_TRGS_RESET;
    end else if (wr_conv) begin
      trgs_reg <= {reg_wdata_in[`PGPFS_TRGS_HIGH_BIT], reg_wdata_in[`PGPFS_TRGS_LOW_BIT]};
    end
  end

  // ========================================================================
  // line 1 function selection
  pgpfs_pkg::pgpfs_mode_grp_t mode_grp;
  pgpfs_pkg::pgpfs_line_fn_t  line1_fn;
  logic                       mode_expanded;
  logic                       line1_direction_bit;
  logic                       line0_direction_bit;

  assign line1_direction_bit = dir_reg[`PGPFS_LINE1_BIT];
  assign line0_direction_bit = dir_reg[`PGPFS_LINE0_BIT];

  // modes 4..6 expand the bus; 0 is reserved and treated as general
  assign mode_expanded = (mode_sync >= `PGPFS_MODE_EXP_LO) &&
                         (mode_sync <= `PGPFS_MODE_EXP_HI);
  assign mode_grp      = mode_expanded ? pgpfs_pkg::PGPFS_GRP_EXPANDED
                                       : pgpfs_pkg::PGPFS_GRP_GENERAL;

  // role from mode group and direction bit
  always_comb begin
    case (mode_grp)
      pgpfs_pkg::PGPFS_GRP_GENERAL: begin
        line1_fn = line1_direction_bit ? pgpfs_pkg::PGPFS_FN_GP_OUT
                                       : pgpfs_pkg::PGPFS_FN_GP_IN;
      end
      pgpfs_pkg::PGPFS_GRP_EXPANDED: begin
        line1_fn = line1_direction_bit ? pgpfs_pkg::PGPFS_FN_CS3_OUT
                                       : pgpfs_pkg::PGPFS_FN_GP_IN;
      end
      default: begin
        line1_fn = pgpfs_pkg::PGPFS_FN_GP_IN;
      end
    endcase
  end

  // next pin values; chip select wins over the latch
  logic line1_out_next;
  logic line1_oe_next;
  logic line0_out_next;
  logic line0_oe_next;

  assign line1_out_next = (line1_fn == pgpfs_pkg::PGPFS_FN_CS3_OUT) ?
                          chip_select_three_n_in
                          : latch_reg[`PGPFS_LINE1_BIT];
  assign line1_oe_next  = (line1_fn != pgpfs_pkg::PGPFS_FN_GP_IN);

  // ========================================================================
  // line 0 function selection, same in every mode
  assign line0_out_next = latch_reg[`PGPFS_LINE0_BIT];
  assign line0_oe_next  = line0_direction_bit;

  // trigger passes only with both source bits set, else held inactive high
  logic trig_sel;
  logic trig_next;

  assign trig_sel  = (trgs_reg == `PGPFS_TRGS_EXT);
  assign trig_next = trig_sel ? pin_level[`PGPFS_LINE0_BIT] : 1'b1;

  // ========================================================================
  // pin drivers, all registered so outputs are glitch free
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_line_one_out     <= 1'b0;
      port_line_one_oe_out  <= 1'b0;
      port_line_zero_out    <= 1'b0;
      port_line_zero_oe_out <= 1'b0;
    end else begin
      port_line_one_out     <= line1_out_next;
      port_line_one_oe_out  <= line1_oe_next;
      port_line_zero_out    <= line0_out_next;
      port_line_zero_oe_out <= line0_oe_next;
    end
  end

  // interrupt levels follow the pins whatever the role; a driven pin
  // loops back too, which is why software should not mix roles
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ext_interrupt_seven_n_out   <= 1'b1;
      ext_interrupt_six_n_out     <= 1'b1;
      converter_ext_trigger_n_out <= 1'b1;
    end else begin
      ext_interrupt_seven_n_out   <= pin_level[`PGPFS_LINE1_BIT];
      ext_interrupt_six_n_out     <= pin_level[`PGPFS_LINE0_BIT];
      converter_ext_trigger_n_out <= trig_next;
    end
  end

  // ========================================================================
  // readback
  logic [`PGPFS_LINES-1:0] pin_view;

  // per line: latch when driving, synchronised pin otherwise
  genvar gi;
  generate
    for (gi = 0; gi < `PGPFS_LINES; gi = gi + 1) begin : g_view
      assign pin_view[gi] = dir_reg[gi] ? latch_reg[gi] : pin_level[gi];
    end
  endgenerate

  logic [`PGPFS_DATA_W-1:0] status_word;
  logic [`PGPFS_DATA_W-1:0] rdata_next;

  // status: mode pins, group, line 1 role, trigger routing
  assign status_word = {1'b0,
                        trig_sel,
                        line1_fn,
                        mode_expanded,
                        mode_sync};

  // upper bits of narrow registers read zero
  assign rdata_next =
      !reg_rd_in ? `PGPFS_RDATA_IDLE :
      hit_dir    ? {6'h00, dir_reg} :
      hit_latch  ? {6'h00, latch_reg} :
      hit_pin    ? {6'h00, pin_view} :
      hit_conv   ? {6'h00, trgs_reg} :
      hit_status ? status_word :
                   `PGPFS_RDATA_IDLE;

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata_out <= `PGPFS_RDATA_IDLE;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

endmodule // pgpfs_top

// ### include/pgpfs_consts.svh
`ifndef PGPFS_CONSTS_SVH
`define PGPFS_CONSTS_SVH

// ==========================================================================
// register bus geometry
`define PGPFS_ADDR_W            8
`define PGPFS_DATA_W            8

// ==========================================================================
// register offsets
`define PGPFS_OFS_DIRECTION     8'h00
`define PGPFS_OFS_OUT_LATCH     8'h01
`define PGPFS_OFS_PIN_LEVEL     8'h02
`define PGPFS_OFS_CONV_CTRL     8'h03
`define PGPFS_OFS_STATUS        8'h04

// ==========================================================================
// field positions
`define PGPFS_LINE0_BIT         0
`define PGPFS_LINE1_BIT         1
`define PGPFS_TRGS_LOW_BIT      0
`define PGPFS_TRGS_HIGH_BIT     1
`define PGPFS_ST_MODE_LSB       0
`define PGPFS_ST_MODE_MSB       2
`define PGPFS_ST_EXPANDED_BIT   3
`define PGPFS_ST_L1FN_LSB       4
`define PGPFS_ST_L1FN_MSB       5
`define PGPFS_ST_L0TRG_BIT      6

// ==========================================================================
// reset values and widths
`define PGPFS_LINES             2
`define PGPFS_MODE_W            3
`define PGPFS_DIR_RESET         2'h0
`define PGPFS_LATCH_RESET       2'h0
`define PGPFS_TRGS_RESET        2'h0
`define PGPFS_TRGS_EXT          2'h3
`define PGPFS_MODE_EXP_LO       3'h4
`define PGPFS_MODE_EXP_HI       3'h6
`define PGPFS_SYNC_W            5
`define PGPFS_RDATA_IDLE        8'h00

`endif

// ### include/pgpfs_pkg.sv
// ==========================================================================
// shared types of the port g low-line pin mux
package pgpfs_pkg;

  // bus-controller mode group, from the mode pins
  typedef enum logic [0:0] {
    PGPFS_GRP_GENERAL,
    PGPFS_GRP_EXPANDED
  } pgpfs_mode_grp_t;

  // current role of line 1
  typedef enum logic [1:0] {
    PGPFS_FN_GP_IN,
    PGPFS_FN_GP_OUT,
    PGPFS_FN_CS3_OUT
  } pgpfs_line_fn_t;

endpackage

// ### core/pgpfs_sync.sv
`timescale 1ns/1ns
`include "pgpfs_consts.svh"

// ==========================================================================
// two-flop synchroniser for pin-level inputs
module pgpfs_sync (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic [`PGPFS_SYNC_W-1:0] async_in,
  output logic      [`PGPFS_SYNC_W-1:0] sync_out
);

  logic [`PGPFS_SYNC_W-1:0] meta_reg;

  // first stage read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pgpfs_sync

// ### dv/pgpfs_board.sv
`timescale 1ns/1ns

// ==========================================================================
// board side of the two low lines
module pgpfs_board (
  input  wire logic one_out_in,
  input  wire logic one_oe_in,
  input  wire logic zero_out_in,
  input  wire logic zero_oe_in,
  input  wire logic drive_one_in,
  input  wire logic drive_zero_in,
  output logic      one_pin_out,
  output logic      zero_pin_out
);
  // board lets go of a line while the chip drives it, never fights it
  assign one_pin_out  = one_oe_in ? one_out_in : drive_one_in;
  assign zero_pin_out = zero_oe_in ? zero_out_in : drive_zero_in;
endmodule // pgpfs_board

// ### dv/pgpfs_properties.sv
`timescale 1ns/1ns
`include "pgpfs_consts.svh"

// ==========================================================================
// port-level checks of the low-line pin mux
module pgpfs_properties (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic [2:0] mode_pins_in,
  input wire logic       chip_select_three_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       port_line_one_in,
  input wire logic       port_line_one_out,
  input wire logic       port_line_one_oe_out,
  input wire logic       port_line_zero_in,
  input wire logic       port_line_zero_out,
  input wire logic       port_line_zero_oe_out,
  input wire logic       ext_interrupt_seven_n_out,
  input wire logic       ext_interrupt_six_n_out,
  input wire logic       converter_ext_trigger_n_out
);
  logic [2:0] age_reg;
  logic [1:0] dir_reg;
  logic [1:0] lat_reg;
  logic [1:0] trg_reg;
  logic       ready;
  // history older than the sync depth is untrusted after reset
  assign ready = (age_reg == 3'h7);
  // mirror of the software-written bits
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      age_reg <= 3'h0;
      dir_reg <= 2'h0;
      lat_reg <= 2'h0;
      trg_reg <= 2'h0;
    end else begin
      age_reg <= ready ? age_reg : age_reg + 3'h1;
      if (reg_wr_in && reg_addr_in == `PGPFS_OFS_DIRECTION) dir_reg <= reg_wdata_in[1:0];
      if (reg_wr_in && reg_addr_in == `PGPFS_OFS_OUT_LATCH) lat_reg <= reg_wdata_in[1:0];
      if (reg_wr_in && reg_addr_in == `PGPFS_OFS_CONV_CTRL) trg_reg <= reg_wdata_in[1:0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_pin_read;
    ready && reg_rd_in && reg_addr_in == `PGPFS_OFS_PIN_LEVEL;
  endsequence

  a_irq_seven_level: assert property (ready |-> ext_interrupt_seven_n_out == $past(port_line_one_in, 3)) else $error("irq seven mismatch");
  a_irq_six_level: assert property (ready |-> ext_interrupt_six_n_out == $past(port_line_zero_in, 3)) else $error("irq six mismatch");
  a_trig_gate: assert property (ready |-> converter_ext_trigger_n_out == (($past(trg_reg) == 2'h3) ? $past(port_line_zero_in, 3) : 1'b1)) else $error("trigger gate wrong");
  a_zero_dir: assert property (ready |-> port_line_zero_oe_out == $past(dir_reg[0])) else $error("line zero enable wrong");
  a_zero_drive: assert property (ready && port_line_zero_oe_out |-> port_line_zero_out == $past(lat_reg[0])) else $error("line zero drive wrong");
  a_one_dir: assert property (ready |-> port_line_one_oe_out == $past(dir_reg[1])) else $error("line one enable wrong");
  a_one_general: assert property (ready && port_line_one_oe_out && !($past(mode_pins_in, 3) inside {[3'h4:3'h6]}) |-> port_line_one_out == $past(lat_reg[1])) else $error("line one latch drive wrong");
  a_one_chip_sel: assert property (ready && port_line_one_oe_out && ($past(mode_pins_in, 3) inside {[3'h4:3'h6]}) |-> port_line_one_out == $past(chip_select_three_n_in)) else $error("line one select drive wrong");
  a_pin_view: assert property (s_pin_read |=> reg_rdata_out == {6'h00, ($past(dir_reg) & $past(lat_reg)) | (~$past(dir_reg) & {$past(port_line_one_in, 3), $past(port_line_zero_in, 3)})}) else $error("pin readback wrong");
endmodule // pgpfs_properties

bind pgpfs_top pgpfs_properties u_props (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .mode_pins_in(mode_pins_in),
  .chip_select_three_n_in(chip_select_three_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .port_line_one_in(port_line_one_in),
  .port_line_one_out(port_line_one_out), .port_line_one_oe_out(port_line_one_oe_out),
  .port_line_zero_in(port_line_zero_in), .port_line_zero_out(port_line_zero_out),
  .port_line_zero_oe_out(port_line_zero_oe_out),
  .ext_interrupt_seven_n_out(ext_interrupt_seven_n_out),
  .ext_interrupt_six_n_out(ext_interrupt_six_n_out),
  .converter_ext_trigger_n_out(converter_ext_trigger_n_out));

// ### dv/tb_pgpfs_top.sv
`timescale 1ns/1ns
`include "pgpfs_consts.svh"

// ==========================================================================
// stimulus, note queue and verdict
module tb_pgpfs_top;
  logic       clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [2:0] mode = 3'h1;
  logic       cs_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       drv_one = 1'b1;
  logic       drv_zero = 1'b1;
  logic       rd_seen = 1'b0;
  logic [7:0] rdata;
  logic       one_in, one_out, one_oe, zero_in, zero_out, zero_oe, ext_interrupt_seven_n, ext_interrupt_six_n, trg_n;
  logic [7:0] exp_q[$];
  logic [31:0] r;
  logic [1:0] dir, lat, trg, view;
  logic       expd;
  int         failures = 0;
  int         compares = 0;
  int         seed = 79;

  always #50 clk_in = ~clk_in;

  pgpfs_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .mode_pins_in(mode),
    .chip_select_three_n_in(cs_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .port_line_one_in(one_in), .port_line_one_out(one_out), .port_line_one_oe_out(one_oe),
    .port_line_zero_in(zero_in), .port_line_zero_out(zero_out),
    .port_line_zero_oe_out(zero_oe), .ext_interrupt_seven_n_out(ext_interrupt_seven_n),
    .ext_interrupt_six_n_out(ext_interrupt_six_n), .converter_ext_trigger_n_out(trg_n));

  pgpfs_board u_board (.one_out_in(one_out), .one_oe_in(one_oe), .zero_out_in(zero_out),
    .zero_oe_in(zero_oe), .drive_one_in(drv_one), .drive_zero_in(drv_zero),
    .one_pin_out(one_in), .zero_pin_out(zero_in));

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // the note goes in before the strobe so the monitor always finds it
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
  endtask

  task automatic wrap_up();
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (rd_seen) check("rdata", exp_q.pop_front(), rdata);
    else if (reset_n_in) check("rdata idle", 8'h00, rdata);
    rd_seen <= rd;
  end

  // cut a hang short, well past the expected run
  initial begin
    #1_000_000;
    failures++;
    wrap_up();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_reg(`PGPFS_OFS_DIRECTION, 8'h00);
    wr_reg(`PGPFS_OFS_PIN_LEVEL, 8'hff);
    wr_reg(8'h07, 8'hff);
    rd_reg(8'h07, 8'h00);
    rd_reg(`PGPFS_OFS_PIN_LEVEL, {6'h00, drv_one, drv_zero});
    // every mode against every trigger setting, random directions and levels
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      dir = r[1:0];
      lat = r[3:2];
      trg = i[4:3];
      expd = (i[2:0] >= 3'h4) && (i[2:0] <= 3'h6);
      @(posedge clk_in);
      mode <= i[2:0];
      cs_n <= r[6];
      drv_one <= r[7];
      drv_zero <= r[8];
      wr_reg(`PGPFS_OFS_DIRECTION, {6'h00, dir});
      wr_reg(`PGPFS_OFS_OUT_LATCH, {6'h00, lat});
      wr_reg(`PGPFS_OFS_CONV_CTRL, {6'h00, trg});
      repeat (4) @(posedge clk_in);
      view = (dir & lat) | (~dir & {drv_one, drv_zero});
      rd_reg(`PGPFS_OFS_PIN_LEVEL, {6'h00, view});
      rd_reg(`PGPFS_OFS_STATUS, {1'b0, trg == 2'h3, dir[1] ? (expd ? 2'h2 : 2'h1) : 2'h0, expd, i[2:0]});
      check("ext_interrupt_seven", {7'h00, dir[1] ? (expd ? cs_n : lat[1]) : drv_one}, {7'h00, ext_interrupt_seven_n});
      check("ext_interrupt_six", {7'h00, view[0]}, {7'h00, ext_interrupt_six_n});
      check("trigger", {7'h00, (trg == 2'h3) ? view[0] : 1'b1}, {7'h00, trg_n});
      check("oe one", {7'h00, dir[1]}, {7'h00, one_oe});
      check("oe zero", {7'h00, dir[0]}, {7'h00, zero_oe});
    end
    repeat (3) @(posedge clk_in);
    wrap_up();
  end
endmodule // tb_pgpfs_top
